/* File: rtl/bprc_top.sv */
// Handshake, bypass routing and locked clock control with Avalon-MM registers
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
//
// Contract
// - Forward controller request-to-send to panel line
// - Offer line request-to-send for loopback selection
// - Clear-to-send from panel line or looped request
// - Hold position keeps clear-to-send always asserted
// - Active-low bypass loops data and controls back
// - Bypass disables the fast data return driver
// - Bypass energizes the voice bypass relay
// - Deliver clock locked to 9600 Hz reference; here the output is the external input or a free-running CLK/2 stand-in
// - Divider is two 8-bit counters plus register
// - Phase compare reference against sync register output
// - Counters reload while sync output is low
// - Count FA82 up to FF01, then reload
// - Sync output low only at terminal count
// - Full cycle spans 1152 generated clock periods
// - Clock source select: external, internal or off
// - Talk return: panel input or looped output
// - Path return: panel input or looped line
// - Enable jumper gates the path return delivery
module bprc_top
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        CTRL_REQUEST_TO_SEND,
    input  wire logic        LINE_CLEAR_TO_SEND,
    input  wire logic        BYPASS_N,
    input  wire logic        REFERENCE_CLOCK_IN,
    input  wire logic        PANEL_TALK_INPUT,
    input  wire logic        PANEL_PATH_INPUT,
    input  wire logic        LOOPED_TALK_SELECT,
    input  wire logic        LOOPED_PATH_SELECT,
    input  wire logic        CTRL_FAST_DATA,
    input  wire logic        CTRL_SLOW_DATA,
    input  wire logic        PANEL_FAST_DATA,
    input  wire logic        PANEL_SLOW_DATA,
    input  wire logic        EXTERNAL_CLOCK_IN,
    output logic             LINE_REQUEST_TO_SEND,
    output logic             CTRL_CLEAR_TO_SEND,
    output logic             TALK_CONTROL_RETURN,
    output logic             PATH_CONTROL_RETURN,
    output logic             FAST_DATA_RETURN,
    output logic             FAST_DATA_RETURN_OE_N,
    output logic             DATA_RETURN_LINE,
    output logic             VOICE_BYPASS_RELAY,
    output logic             MASTER_CLOCK_OUT,
    output logic             MASTER_CLOCK_OE_N,
    output logic             PHASE_UP,
    output logic             PHASE_DOWN
);
    import bprc_pkg::*;

    // Filter: a change counts once stages two and three agree
    function automatic logic [NUM_PINS-1:0] settle(
        input logic [NUM_PINS-1:0] s2,
        input logic [NUM_PINS-1:0] s3,
        input logic [NUM_PINS-1:0] held);
        settle = (s2 & s3) | (held & (s2 ^ s3));
    endfunction

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Pin synchroniser
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] pin_s1_q;
    logic [NUM_PINS-1:0] pin_s2_q;
    logic [NUM_PINS-1:0] pin_s3_q;
    logic [NUM_PINS-1:0] pin_q;

    assign pin_raw = {EXTERNAL_CLOCK_IN, PANEL_SLOW_DATA, PANEL_FAST_DATA,
                      CTRL_SLOW_DATA, CTRL_FAST_DATA, LOOPED_PATH_SELECT,
                      LOOPED_TALK_SELECT, PANEL_PATH_INPUT, PANEL_TALK_INPUT,
                      REFERENCE_CLOCK_IN, BYPASS_N, LINE_CLEAR_TO_SEND,
                      CTRL_REQUEST_TO_SEND};

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pin_s1_q <= 13'h0004;
            pin_s2_q <= 13'h0004;
            pin_s3_q <= 13'h0004;
            pin_q    <= 13'h0004;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q    <= settle(pin_s2_q, pin_s3_q, pin_q);
        end
    end

    logic rts_f;
    logic line_cts_f;
    logic bypass_n_f;
    logic ref_f;
    logic panel_talk_f;
    logic panel_path_f;
    logic loop_talk_f;
    logic loop_path_f;
    logic ctrl_fast_f;
    logic ctrl_slow_f;
    logic panel_fast_f;
    logic panel_slow_f;
    logic ext_clk_f;
    logic bypass;

    assign {ext_clk_f, panel_slow_f, panel_fast_f, ctrl_slow_f, ctrl_fast_f,
            loop_path_f, loop_talk_f, panel_path_f, panel_talk_f, ref_f,
            bypass_n_f, line_cts_f, rts_f} = pin_q;
    assign bypass = !bypass_n_f;

    // Control register
    logic [1:0] hs_sel_q;
    logic [1:0] clk_src_q;
    logic       ad_en_q;
    logic       ack_q;
    logic       req;

    assign req             = AVS_READ || AVS_WRITE;
    assign AVS_WAITREQUEST = req && !ack_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req && !ack_q;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            hs_sel_q  <= HS_SEL_RESET;
            clk_src_q <= CLK_SRC_RESET;
            ad_en_q   <= AD_EN_RESET;
        end
        else if (AVS_WRITE && ack_q && AVS_BYTEENABLE[0] && hit(AVS_ADDRESS, CONTROL_OFS))
        begin
            hs_sel_q  <= AVS_WRITEDATA[HS_SEL_LSB +: 2];
            clk_src_q <= AVS_WRITEDATA[CLK_SRC_LSB +: 2];
            ad_en_q   <= AVS_WRITEDATA[AD_EN_BIT];
        end
    end

    // Prescaler and phase comparator
    logic [15:0] count;
    logic        sync_n;
    logic        sync_n_q;
    logic        ref_q;
    logic        ref_rise;
    logic        cmp_fall;
    logic        up_q;
    logic        down_q;
    logic [15:0] pulses_q;

    bprc_prescaler u_prescaler
    (
        .clk    (CLK),
        .rst    (RST),
        .count  (count),
        .sync_n (sync_n)
    );

    assign ref_rise = ref_f && !ref_q;
    assign cmp_fall = !sync_n && sync_n_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ref_q    <= 1'b0;
            sync_n_q <= 1'b1;
            up_q     <= 1'b0;
            down_q   <= 1'b0;
            pulses_q <= 16'h0000;
        end
        else
        begin
            ref_q    <= ref_f;
            sync_n_q <= sync_n;
            // Edges that meet in one cycle clear both flags, so the loop filter sees no error
            up_q     <= (up_q || ref_rise) && !(down_q || cmp_fall);
            down_q   <= (down_q || cmp_fall) && !(up_q || ref_rise);
            if (cmp_fall)
            begin
                pulses_q <= pulses_q + 16'h0001;
            end
        end
    end

    assign PHASE_UP   = up_q;
    assign PHASE_DOWN = down_q;

    // Stand-in oscillator: this logic cannot run at the locked rate itself
    logic osc_q;
    logic mclk_q;
    logic mclk_oe_n_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            osc_q       <= 1'b0;
            mclk_q      <= 1'b0;
            mclk_oe_n_q <= 1'b1;
        end
        else
        begin
            osc_q       <= !osc_q;
            mclk_q      <= (clk_src_q == CLK_EXTERNAL) ? ext_clk_f :
                           (clk_src_q == CLK_INTERNAL) ? osc_q : 1'b0;
            mclk_oe_n_q <= !(clk_src_q == CLK_EXTERNAL || clk_src_q == CLK_INTERNAL);
        end
    end

    assign MASTER_CLOCK_OUT  = mclk_q;
    assign MASTER_CLOCK_OE_N = mclk_oe_n_q;

    // Handshake and bypass routing, registered
    logic rts_out_q;
    logic cts_out_q;
    logic talk_q;
    logic path_q;
    logic fast_q;
    logic fast_oe_n_q;
    logic slow_q;
    logic relay_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rts_out_q   <= 1'b0;
            cts_out_q   <= 1'b0;
            talk_q      <= 1'b0;
            path_q      <= 1'b0;
            fast_q      <= 1'b0;
            fast_oe_n_q <= 1'b1;
            slow_q      <= 1'b0;
            relay_q     <= 1'b0;
        end
        else
        begin
            rts_out_q <= rts_f;
            unique case (hs_sel_q)
                HS_LOOP: cts_out_q <= rts_f;
                HS_HOLD: cts_out_q <= 1'b1;
                default: cts_out_q <= line_cts_f;
            endcase
            talk_q      <= bypass ? loop_talk_f : panel_talk_f;
            path_q      <= ad_en_q && (bypass ? loop_path_f : panel_path_f);
            fast_q      <= bypass ? ctrl_fast_f : panel_fast_f;
            fast_oe_n_q <= bypass;
            slow_q      <= bypass ? ctrl_slow_f : panel_slow_f;
            relay_q     <= bypass;
        end
    end

    assign LINE_REQUEST_TO_SEND  = rts_out_q;
    assign CTRL_CLEAR_TO_SEND    = cts_out_q;
    assign TALK_CONTROL_RETURN   = talk_q;
    assign PATH_CONTROL_RETURN   = path_q;
    assign FAST_DATA_RETURN      = fast_q;
    assign FAST_DATA_RETURN_OE_N = fast_oe_n_q;
    assign DATA_RETURN_LINE      = slow_q;
    assign VOICE_BYPASS_RELAY    = relay_q;

    // Read data captured on the first cycle, stands on the answer cycle
    logic [31:0] rdata_q;
    logic [31:0] status;

    assign status = {26'h0000000, down_q, up_q, sync_n, cts_out_q, rts_out_q, bypass};

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rdata_q <= 32'h00000000;
        end
        else if (AVS_READ && !ack_q)
        begin
            if (hit(AVS_ADDRESS, CONTROL_OFS))
                rdata_q <= {27'h0000000, ad_en_q, clk_src_q, hs_sel_q};
            else if (hit(AVS_ADDRESS, STATUS_OFS))
                rdata_q <= status;
            else if (hit(AVS_ADDRESS, COUNT_OFS))
                rdata_q <= {16'h0000, count};
            else if (hit(AVS_ADDRESS, PULSES_OFS))
                rdata_q <= {16'h0000, pulses_q};
            else
                rdata_q <= 32'h00000000;
        end
    end

    assign AVS_READDATA = rdata_q;

    rts_forward_a: assert property (@(posedge CLK) disable iff (RST)
        ##1 LINE_REQUEST_TO_SEND == $past(rts_f))
        else $error("line request-to-send does not follow controller");

    hs_loop_a: assert property (@(posedge CLK) disable iff (RST)
        (hs_sel_q == HS_LOOP && $stable(hs_sel_q)) |=> CTRL_CLEAR_TO_SEND == $past(rts_f))
        else $error("looped clear-to-send does not follow request");

    hs_hold_a: assert property (@(posedge CLK) disable iff (RST)
        (hs_sel_q == HS_HOLD) |=> CTRL_CLEAR_TO_SEND)
        else $error("held clear-to-send dropped");

    talk_route_a: assert property (@(posedge CLK) disable iff (RST)
        bypass |=> TALK_CONTROL_RETURN == $past(loop_talk_f))
        else $error("talk return not looped in bypass");

    path_gate_a: assert property (@(posedge CLK) disable iff (RST)
        !ad_en_q |=> !PATH_CONTROL_RETURN)
        else $error("path return delivered while disabled");

    fast_tristate_a: assert property (@(posedge CLK) disable iff (RST)
        bypass [*2] |-> FAST_DATA_RETURN_OE_N)
        else $error("fast data return driven during bypass");

    relay_bypass_a: assert property (@(posedge CLK) disable iff (RST)
        $rose(bypass) |=> VOICE_BYPASS_RELAY)
        else $error("voice relay not energized on bypass");

    clock_off_a: assert property (@(posedge CLK) disable iff (RST)
        (clk_src_q == CLK_OFF) |=> MASTER_CLOCK_OE_N)
        else $error("master clock driven while disabled");

    phase_up_a: assert property (@(posedge CLK) disable iff (RST)
        (ref_rise && !cmp_fall && !down_q) |=> PHASE_UP)
        else $error("reference edge did not raise phase up");
endmodule

/* File: common/bprc_pkg.sv */
// Shared constants and types for the bypass routing and clock prescaler block
package bprc_pkg;
    // Rates and the derived divide ratio
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned REF_HZ       = 9_600;
    localparam int unsigned GEN_HZ       = 11_059_200;
    localparam int unsigned DIVIDE_RATIO = GEN_HZ / REF_HZ;

    // Prescaler counter values
    localparam logic [7:0]  RELOAD_UPPER = 8'hfa;
    localparam logic [7:0]  RELOAD_LOWER = 8'h82;
    localparam logic [15:0] LAST_COUNT   = 16'hff00;
    localparam logic [15:0] TERM_COUNT   = 16'hff01;

    // Register byte offsets
    localparam logic [3:0] CONTROL_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS  = 4'h4;
    localparam logic [3:0] COUNT_OFS   = 4'h8;
    localparam logic [3:0] PULSES_OFS  = 4'hc;

    // Control field positions and reset values
    localparam int unsigned HS_SEL_LSB  = 0;
    localparam int unsigned CLK_SRC_LSB = 2;
    localparam int unsigned AD_EN_BIT   = 4;

    typedef enum logic [1:0] {
        HS_PANEL = 2'b00,
        HS_LOOP  = 2'b01,
        HS_HOLD  = 2'b10
    } bprc_hs_sel_t;

    typedef enum logic [1:0] {
        CLK_OFF      = 2'b00,
        CLK_INTERNAL = 2'b01,
        CLK_EXTERNAL = 2'b10
    } bprc_clk_src_t;

    localparam logic [1:0] HS_SEL_RESET  = 2'b00;
    localparam logic [1:0] CLK_SRC_RESET = 2'b01;
    localparam logic       AD_EN_RESET   = 1'b1;

    // Status field positions
    localparam int unsigned ST_BYPASS_BIT = 0;
    localparam int unsigned ST_RTS_BIT    = 1;
    localparam int unsigned ST_CTS_BIT    = 2;
    localparam int unsigned ST_SYNC_BIT   = 3;
    localparam int unsigned ST_UP_BIT     = 4;
    localparam int unsigned ST_DOWN_BIT   = 5;

    // Pin inputs that cross into the clock domain
    localparam int unsigned NUM_PINS = 13;
endpackage

/* File: rtl/bprc_prescaler.sv */
// Divide-by-1152 feedback prescaler: two byte counters and the sync register
`timescale 1ns/1ns
module bprc_prescaler
(
    input  wire logic        clk,
    input  wire logic        rst,
    output logic [15:0]      count,
    output logic             sync_n
);
    import bprc_pkg::*;

    logic [7:0] upper_count_byte_q;
    logic [7:0] lower_count_byte_q;
    logic       sync_register_q;
    logic       carry;

    assign carry  = (lower_count_byte_q == 8'hff);
    assign count  = {upper_count_byte_q, lower_count_byte_q};
    assign sync_n = sync_register_q;

    // Reload while the sync output is low; plain counting otherwise
    always_ff @(posedge clk)
    begin
        if (rst || !sync_register_q)
        begin
            upper_count_byte_q <= RELOAD_UPPER;
            lower_count_byte_q <= RELOAD_LOWER;
        end
        else
        begin
            lower_count_byte_q <= lower_count_byte_q + 8'h01;
            if (carry)
            begin
                upper_count_byte_q <= upper_count_byte_q + 8'h01;
            end
        end
    end

    // Low for the single terminal-count period of each cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync_register_q <= 1'b1;
        end
        else
        begin
            sync_register_q <= !(sync_register_q && count == LAST_COUNT);
        end
    end

    // Helper: periods since the previous compare pulse
    logic [11:0] gap_q;
    logic        seen_q;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gap_q  <= 12'h000;
            seen_q <= 1'b0;
        end
        else if (!sync_register_q)
        begin
            gap_q  <= 12'h001;
            seen_q <= 1'b1;
        end
        else
        begin
            gap_q <= gap_q + 12'h001;
        end
    end

    sequence pulse_seq;
        !sync_register_q ##1 sync_register_q;
    endsequence

    reload_value_a: assert property (@(posedge clk) disable iff (rst)
        pulse_seq |-> count == {RELOAD_UPPER, RELOAD_LOWER})
        else $error("counters did not reload after the compare pulse");

    pulse_at_term_a: assert property (@(posedge clk) disable iff (rst)
        !sync_register_q |-> count == TERM_COUNT ##1 sync_register_q)
        else $error("compare pulse not at terminal count or too long");

    cycle_length_a: assert property (@(posedge clk) disable iff (rst)
        (!sync_register_q && seen_q) |-> gap_q == 12'(DIVIDE_RATIO))
        else $error("prescaler cycle is not 1152 periods");
endmodule

/* File: dv/bprc_panel_model.sv */
// Panel-side model: handshake, talk, path, data levels and the two clocks
`timescale 1ns/1ns
module bprc_panel_model
(
    input  wire logic       clk,
    input  wire logic [4:0] want,
    output logic            cts,
    output logic            talk,
    output logic            path,
    output logic            fast,
    output logic            slow,
    output logic            ref_clk,
    output logic            ext_clk
);
    int ref_cnt = 0;
    int ext_cnt = 0;

    initial
    begin
        ref_clk = 1'b0;
        ext_clk = 1'b0;
    end

    // Levels change only just after a rising edge
    always @(posedge clk)
        {cts, talk, path, fast, slow} <= want;

    // Reference at CLK/1152 so a locked loop sees a matching rate
    always @(posedge clk)
    begin
        ref_cnt <= (ref_cnt == 575) ? 0 : ref_cnt + 1;
        if (ref_cnt == 575)
            ref_clk <= ~ref_clk;
        // Slow external source, long enough to pass the pin filter
        ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
        if (ext_cnt == 2)
            ext_clk <= ~ext_clk;
    end
endmodule

/* File: dv/bypass_routing_clock_prescaler_tb.sv */
// Self-checking bench for the bypass routing and clock prescaler block
`timescale 1ns/1ns
module bypass_routing_clock_prescaler_tb;
    import bprc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hf;
    logic [31:0] rdata;
    logic        waitreq;
    logic        c_rts = 1'b0;
    logic        bypass_n = 1'b1;
    logic        loop_talk = 1'b0;
    logic        loop_path = 1'b0;
    logic        c_fast = 1'b0;
    logic        c_slow = 1'b0;
    logic [4:0]  want = 5'h0;
    logic        p_cts, p_talk, p_path, p_fast, p_slow, p_ref, p_ext;
    logic        l_rts, c_cts, talk_ret, path_ret, fast_ret, fast_oe_n;
    logic        slow_ret, relay, mclk, mclk_oe_n, ph_up, ph_dn;
    logic [31:0] seed = 32'h2e;
    logic [31:0] q, r, c1, c2, expv;
    logic        bp, en, prev;
    int          miscompares = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          tog;
    int          both;
    int          act;

    always #50 clk = ~clk;

    bprc_panel_model i_panel (.clk(clk), .want(want), .cts(p_cts), .talk(p_talk),
        .path(p_path), .fast(p_fast), .slow(p_slow), .ref_clk(p_ref), .ext_clk(p_ext));

    bprc_top i_dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq), .CTRL_REQUEST_TO_SEND(c_rts),
        .LINE_CLEAR_TO_SEND(p_cts), .BYPASS_N(bypass_n), .REFERENCE_CLOCK_IN(p_ref),
        .PANEL_TALK_INPUT(p_talk), .PANEL_PATH_INPUT(p_path),
        .LOOPED_TALK_SELECT(loop_talk), .LOOPED_PATH_SELECT(loop_path),
        .CTRL_FAST_DATA(c_fast), .CTRL_SLOW_DATA(c_slow), .PANEL_FAST_DATA(p_fast),
        .PANEL_SLOW_DATA(p_slow), .EXTERNAL_CLOCK_IN(p_ext),
        .LINE_REQUEST_TO_SEND(l_rts), .CTRL_CLEAR_TO_SEND(c_cts),
        .TALK_CONTROL_RETURN(talk_ret), .PATH_CONTROL_RETURN(path_ret),
        .FAST_DATA_RETURN(fast_ret), .FAST_DATA_RETURN_OE_N(fast_oe_n),
        .DATA_RETURN_LINE(slow_ret), .VOICE_BYPASS_RELAY(relay),
        .MASTER_CLOCK_OUT(mclk), .MASTER_CLOCK_OE_N(mclk_oe_n),
        .PHASE_UP(ph_up), .PHASE_DOWN(ph_dn));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One access; held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b, output logic [31:0] rq);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        do
            @(posedge clk);
        while (waitreq !== 1'b0);
        rq = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // Pin paths need about five edges through the filters
    task automatic settle();
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        expv = 32'(AD_EN_RESET) << AD_EN_BIT | 32'(CLK_SRC_RESET) << CLK_SRC_LSB
             | 32'(HS_SEL_RESET) << HS_SEL_LSB;
        bus(1'b0, CONTROL_OFS, 32'h0, 4'hf, q);
        check("control reset", expv, q);
        bus(1'b1, CONTROL_OFS, 32'h1b, 4'he, q);
        bus(1'b1, STATUS_OFS, 32'hff, 4'hf, q);
        bus(1'b1, 4'h2, 32'hff, 4'hf, q);
        bus(1'b0, 4'h2, 32'h0, 4'hf, q);
        check("unmapped read", 32'h0, q);
        bus(1'b0, CONTROL_OFS, 32'h0, 4'hf, q);
        check("control kept", expv, q);
        // Every handshake select code against every pin pair
        for (int hs = 0; hs < 4; hs++)
        begin
            bus(1'b1, CONTROL_OFS, 32'h14 | hs, 4'hf, q);
            for (int v = 0; v < 4; v++)
            begin
                @(posedge clk);
                c_rts <= v[0];
                want <= {v[1], 4'h0};
                settle();
                check("line rts", v[0], l_rts);
                expv = (hs == 1) ? v[0] : (hs == 2) ? 1 : v[1];
                check("ctrl cts", expv, c_cts);
                bus(1'b0, STATUS_OFS, 32'h0, 4'hf, q);
                check("status rts cts", {expv[0], v[0]}, q[2:1]);
            end
        end
        // Bypass alternates while every other level except controller request-to-send is random
        for (int i = 0; i < 10; i++)
        begin
            r = xs();
            bp = i[0];
            en = r[10];
            bus(1'b1, CONTROL_OFS, 32'h04 | 32'(en) << 4, 4'hf, q);
            @(posedge clk);
            bypass_n <= !bp;
            c_fast <= r[1];
            c_slow <= r[2];
            loop_talk <= r[3];
            loop_path <= r[4];
            want <= r[9:5];
            settle();
            check("talk return", bp ? r[3] : r[8], talk_ret);
            check("path return", en & (bp ? r[4] : r[7]), path_ret);
            check("slow return", bp ? r[2] : r[5], slow_ret);
            check("fast driver off", bp, fast_oe_n);
            check("fast return", bp ? r[1] : r[6], fast_ret);
            check("voice relay", bp, relay);
        end
        // Clock source select: off, internal, external, off
        for (int s = 0; s < 4; s++)
        begin
            bus(1'b1, CONTROL_OFS, 32'h10 | s << 2, 4'hf, q);
            settle();
            tog = 0;
            prev = mclk;
            repeat (24)
            begin
                @(negedge clk);
                tog += (mclk !== prev);
                prev = mclk;
            end
            check("clock driver", (s == 1 || s == 2) ? 0 : 1, mclk_oe_n);
            if (s == 1 || s == 2)
                check("clock running", 1, tog != 0);
        end
        // Prescaler: range, step of 100 cycles, full period, pulse rate
        bus(1'b0, COUNT_OFS, 32'h0, 4'hf, c1);
        check("count range", 1, c1[15:0] >= 16'hfa82 && c1[15:0] <= TERM_COUNT);
        repeat (97) @(posedge clk);
        bus(1'b0, COUNT_OFS, 32'h0, 4'hf, c2);
        expv = c1[15:0] + 100;
        if (expv > 32'hff01)
            expv = expv - 1152;
        check("count step", expv, c2[15:0]);
        repeat (1149) @(posedge clk);
        bus(1'b0, COUNT_OFS, 32'h0, 4'hf, q);
        check("count period", c2[15:0], q[15:0]);
        bus(1'b0, PULSES_OFS, 32'h0, 4'hf, c1);
        // Same rate on both inputs: one phase flag may lead, never both at once
        both = 0;
        act = 0;
        repeat (3453)
        begin
            @(posedge clk);
            both += ph_up & ph_dn;
            act += ph_up | ph_dn;
        end
        bus(1'b0, PULSES_OFS, 32'h0, 4'hf, c2);
        check("pulse rate", 16'(c1[15:0] + 16'h3), c2[15:0]);
        check("phase both", 0, both);
        check("phase active", 1, act != 0);
        finish_test();
    end
endmodule
